// ==== ascr_consts.svh ====
// Timing and configuration constants for the converter serial logic.
// Assumes a 50 MHz system clock sampling all link pins.
`ifndef ASCR_CONSTS_SVH
`define ASCR_CONSTS_SVH
`define ASCR_CLK_NS        20
`define ASCR_CONVERSION_TIME_MAX_NS  2200
`define ASCR_CONVERSION_TIME_MIN_NS  500
`define ASCR_CONV_MAX_CYC  ((`ASCR_CONVERSION_TIME_MAX_NS) / (`ASCR_CLK_NS))
`define ASCR_CONV_MIN_CYC  ((`ASCR_CONVERSION_TIME_MIN_NS + `ASCR_CLK_NS - 1) / `ASCR_CLK_NS)
`define ASCR_CFG_W         14
`define ASCR_CFG_LOAD_EDGE 14
`define ASCR_DATA_EDGES    16
`define ASCR_CFG_DEFAULT   14'h3FFF
`define ASCR_CFG_REF_LSB   3
`define ASCR_CFG_REF_MSB   5
`define ASCR_CFG_RB_BIT    0
`endif

// ==== ascr_pkg.sv ====
// Types shared by the converter serial logic.
// Assumes nothing beyond the constants header.
package ascr_pkg;
	typedef enum logic [2:0] {
		ASCR_ACQ  = 3'b001,
		ASCR_CONV = 3'b010,
		ASCR_DONE = 3'b100
	} ascr_phase_t;
endpackage

// ==== ascr_result_mem.sv ====
// Result holding register: keeps the last completed conversion word.
// Assumes a write only at the end of a conversion.
`timescale 1ns/1ps
`default_nettype none
module ascr_result_mem #(
	parameter int W = 16
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_resetn,
	input  wire logic         i_wr,
	input  wire logic [W-1:0] i_wdata,
	output logic      [W-1:0] o_rdata
);
	initial begin
		if (W < 1) $error("bad width");
	end
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			o_rdata <= '0;
		end else if (i_wr) begin
			o_rdata <= i_wdata;
		end
	end
endmodule
`default_nettype wire

// ==== ascr_top.sv ====
// Conversion control and four-wire serial logic of the converter.
// Assumes pins arrive asynchronously; sampled by i_clk_sys.
//
// Notes on behaviour
// - Conversions start only from the conversion start line.
// - Config input high at first falling edge loads word at edge fourteen.
// - After edge fourteen further config data ignored until max conversion time.
// - Config word accepted during the same transfer that reads data.
// - Factory default configuration used until host writes one.
// - Result readable during acquisition or after conversion, not during it.
// - Output stays released during conversion; the new result is read after it.
// - Optional start bit precedes result as busy indication.
// - Busy indication enabled only if start line low before max time.
// - Device powers down at the end of every conversion.
// - Reference and buffer power down separately or together by config.
// - Start line rising begins conversion, output goes high impedance.
// - Output released after sixteenth falling edge (seventeenth in busy mode) or start line rise.
// - In busy mode output driven when conversion completes.
`timescale 1ns/1ps
`default_nettype none
`include "ascr_consts.svh"
module ascr_top
	import ascr_pkg::*;
#(
	parameter int CONV_MAX_CYC = `ASCR_CONV_MAX_CYC,
	parameter int RES_W        = 16
) (
	input  wire logic             i_clk_sys,
	input  wire logic             i_resetn,
	input  wire logic             i_conversion_start_line,
	input  wire logic             i_sck,
	input  wire logic             i_cfg_din,
	input  wire logic [RES_W-1:0] i_sample,
	output logic                  o_serial_result_output,
	output logic                  o_serial_result_output_oe_n,
	output logic [`ASCR_CFG_W-1:0] o_cfg,
	output logic                  o_powered_down,
	output logic                  o_ref_pd,
	output logic                  o_buf_pd
);
	initial begin
		if (CONV_MAX_CYC < 2 || CONV_MAX_CYC > 4096) $error("bad count");
		if (RES_W != 16) $error("width must be 16");
	end

	// Two-stage synchronisers; stage one read only by stage two
	logic [2:0] s1_reg, s2_reg, s3_reg;
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			s1_reg <= 3'h0;
			s2_reg <= 3'h0;
			s3_reg <= 3'h0;
		end else begin
			s1_reg <= {i_conversion_start_line, i_sck, i_cfg_din};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	logic conversion_start_line, din, cnv_rise, sck_fall;
	assign conversion_start_line      = s2_reg[2];
	assign din      = s2_reg[0];
	assign cnv_rise = s2_reg[2] & ~s3_reg[2];
	assign sck_fall = ~s2_reg[1] & s3_reg[1];

	// Conversion phase
	ascr_phase_t phase_reg;
	logic [12:0] conv_cnt_reg;
	logic        conv_end;
	assign conv_end = (phase_reg == ASCR_CONV)
		&& (conv_cnt_reg == 13'(CONV_MAX_CYC - 1));
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			phase_reg    <= ASCR_ACQ;
			conv_cnt_reg <= 13'h0000;
		end else begin
			unique case (phase_reg)
				ASCR_ACQ, ASCR_DONE: begin
					conv_cnt_reg <= 13'h0000;
					if (cnv_rise) begin
						phase_reg <= ASCR_CONV;
					end else begin
						phase_reg <= ASCR_ACQ;
					end
				end
				ASCR_CONV: begin
					conv_cnt_reg <= conv_cnt_reg + 13'h0001;
					if (conv_end) begin
						phase_reg <= ASCR_DONE;
					end
				end
			endcase
		end
	end
	// Power down outside conversions, scales power with rate
	assign o_powered_down = (phase_reg != ASCR_CONV);

	// Busy mode decided at conversion end: start line still held low.
	// Deciding on entry failed, since the line is high as it rises.
	logic busy_en_reg;
	logic busy_now;
	assign busy_now = conv_end && !conversion_start_line;
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			busy_en_reg <= 1'b0;
		end else if (cnv_rise) begin
			busy_en_reg <= 1'b0;
		end else if (conv_end) begin
			busy_en_reg <= !conversion_start_line;
		end
	end

	// Result store: old word stays visible until conversion ends
	logic [RES_W-1:0] result;
	ascr_result_mem #(.W(RES_W)) u_mem (
		.i_clk_sys (i_clk_sys),
		.i_resetn  (i_resetn),
		.i_wr      (conv_end),
		.i_wdata   (i_sample),
		.o_rdata   (result)
	);

	// Serial transfer: shift out result, shift in config
	logic [4:0]             edge_cnt_reg;
	logic                   cfg_wr_reg;
	logic                   cfg_lock_reg;
	logic [`ASCR_CFG_W-1:0] cfg_sh_reg;
	logic [RES_W:0]         out_sh_reg;
	logic                   oe_reg;
	logic [4:0]             last_edge;
	assign last_edge = busy_en_reg ? 5'(`ASCR_DATA_EDGES + 1)
		: 5'(`ASCR_DATA_EDGES);

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			edge_cnt_reg <= 5'h00;
			cfg_wr_reg   <= 1'b0;
			cfg_sh_reg   <= '0;
		end else if (cnv_rise || conv_end) begin
			// Readout after the end is a fresh frame
			edge_cnt_reg <= 5'h00;
			cfg_wr_reg   <= 1'b0;
		end else if (sck_fall) begin
			if (edge_cnt_reg != 5'h1F) begin
				edge_cnt_reg <= edge_cnt_reg + 5'h01;
			end
			if (edge_cnt_reg == 5'h00) begin
				cfg_wr_reg <= din & ~cfg_lock_reg;
			end
			cfg_sh_reg <= {cfg_sh_reg[`ASCR_CFG_W-2:0], din};
		end
	end

	// Lock after a load until max conversion time has passed;
	// a load in the last conversion cycle wins over the clear
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			cfg_lock_reg <= 1'b0;
		end else if (sck_fall && cfg_wr_reg
			&& edge_cnt_reg == 5'(`ASCR_CFG_LOAD_EDGE - 1)) begin
			cfg_lock_reg <= 1'b1;
		end else if (conv_end) begin
			cfg_lock_reg <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			o_cfg <= `ASCR_CFG_DEFAULT;
		end else if (sck_fall && cfg_wr_reg && !cfg_lock_reg
			&& edge_cnt_reg == 5'(`ASCR_CFG_LOAD_EDGE - 1)) begin
			o_cfg <= {cfg_sh_reg[`ASCR_CFG_W-2:0], din};
		end
	end
	// Reference field: top bit arms power-down, lower bits pick which;
	// both picked gives the lowest power
	assign o_ref_pd = o_cfg[`ASCR_CFG_REF_MSB]
		& o_cfg[`ASCR_CFG_REF_MSB - 1];
	assign o_buf_pd = o_cfg[`ASCR_CFG_REF_MSB]
		& o_cfg[`ASCR_CFG_REF_LSB];

	// Output driver
	always_ff @(posedge i_clk_sys) begin
		if (!i_resetn) begin
			oe_reg     <= 1'b0;
			out_sh_reg <= '0;
		end else if (cnv_rise) begin
			oe_reg <= 1'b0;
		end else if (busy_now) begin
			oe_reg     <= 1'b1;
			out_sh_reg <= {1'b0, i_sample};
		end else if (phase_reg != ASCR_CONV && !busy_en_reg
			&& !conversion_start_line && !oe_reg && edge_cnt_reg == 5'h00) begin
			oe_reg     <= 1'b1;
			out_sh_reg <= {result, 1'b0};
		end else if (sck_fall && oe_reg) begin
			out_sh_reg <= {out_sh_reg[RES_W-1:0], 1'b0};
			if (edge_cnt_reg + 5'h01 == last_edge) begin
				oe_reg <= 1'b0;
			end
		end
	end
	assign o_serial_result_output      = out_sh_reg[RES_W];
	assign o_serial_result_output_oe_n = ~oe_reg;

	chk_conv_len: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		$rose(phase_reg == ASCR_CONV) |->
		(phase_reg == ASCR_CONV)[*2]) else $error("conversion too short");
	chk_rise_hiz: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		cnv_rise |=> !oe_reg) else $error("output not released");
	chk_cfg_hold: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		cfg_lock_reg |=> $stable(o_cfg)) else $error("config changed locked");
	chk_pd_idle: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		conv_end |=> o_powered_down) else $error("no power down");
	chk_busy_drive: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		busy_now |=> !o_serial_result_output_oe_n
		&& !o_serial_result_output) else $error("no start bit");
	chk_result_keep: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		(phase_reg == ASCR_CONV && !conv_end) |=> $stable(result))
		else $error("result changed mid conversion");
	chk_nocfg_keep: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		!cfg_wr_reg |=> $stable(o_cfg)) else $error("config changed");
	chk_edge_release: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		(sck_fall && oe_reg && !cnv_rise && !conv_end
		&& edge_cnt_reg == 5'(`ASCR_DATA_EDGES - 1) && !busy_en_reg)
		|=> !oe_reg) else $error("output held past last edge");
endmodule
`default_nettype wire

// ==== ascr_host.sv ====
// Host model: drives start line, serial clock and config input.
// Assumes a 50 MHz bench clock; one serial clock period is 8 clocks.
`timescale 1ns/1ps
`default_nettype none
module ascr_host (
	input  wire logic i_clk_sys,
	input  wire logic i_sdo,
	input  wire logic i_oe_n,
	output logic      o_cnv,
	output logic      o_sck,
	output logic      o_din,
	output logic      o_cap_v,
	output logic      o_cap_b
);
	initial begin
		o_cnv = 1'b0;
		o_sck = 1'b1;
		o_din = 1'b0;
		o_cap_v = 1'b0;
	end
	// Serial clock and config input held still around the rise
	task automatic start(input logic busy);
		@(posedge i_clk_sys);
		o_cnv <= 1'b1;
		repeat (2) @(posedge i_clk_sys);
		o_cnv <= !busy;
	endtask
	task automatic drop();
		@(posedge i_clk_sys);
		o_cnv <= 1'b0;
	endtask
	// Bursts only; a released output is captured as unknown
	task automatic xfer(input int n, input logic [16:0] d, input logic cap);
		for (int i = n - 1; i >= 0; i--) begin
			@(posedge i_clk_sys);
			o_din <= d[i];
			repeat (3) @(posedge i_clk_sys);
			o_sck <= 1'b0;
			o_cap_v <= cap;
			o_cap_b <= (i_oe_n === 1'b0) ? i_sdo : 1'bx;
			@(posedge i_clk_sys);
			o_cap_v <= 1'b0;
			repeat (3) @(posedge i_clk_sys);
			o_sck <= 1'b1;
		end
	endtask
endmodule
`default_nettype wire

// ==== tb_ascr_top.sv ====
// Bench for the converter serial logic: host model plus result queue.
// Assumes the design files and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_ascr_top;
	localparam int CONV = 130;
	logic        clk, resetn, conversion_start_line, sck, din, serial_result_output, oe_n, pd;
	logic        ref_pd, buf_pd, cap_v, cap_b, e1;
	logic [15:0] sample;
	logic [13:0] cfg, w;
	logic        exp_q[$];
	int          seed, fail_count, total_checks;
	ascr_top #(.CONV_MAX_CYC(CONV)) dut (
		.i_clk_sys(clk), .i_resetn(resetn), .i_conversion_start_line(conversion_start_line),
		.i_sck(sck), .i_cfg_din(din), .i_sample(sample),
		.o_serial_result_output(serial_result_output), .o_serial_result_output_oe_n(oe_n),
		.o_cfg(cfg), .o_powered_down(pd), .o_ref_pd(ref_pd), .o_buf_pd(buf_pd)
	);
	ascr_host host (
		.i_clk_sys(clk), .i_sdo(serial_result_output), .i_oe_n(oe_n), .o_cnv(conversion_start_line), .o_sck(sck),
		.o_din(din), .o_cap_v(cap_v), .o_cap_b(cap_b)
	);
	task automatic check(input string nm, input logic [15:0] g, e);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic check_bit(input logic g, e);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error sdo expected %b seen %b", e, g);
		end
	endtask
	task automatic conclude();
		if (fail_count == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic push(input logic busy, input logic [15:0] s);
		if (busy) exp_q.push_back(1'b0);
		for (int i = 15; i >= 0; i--) exp_q.push_back(s[i]);
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) if (cap_v === 1'b1) begin
		e1 = exp_q.size() ? exp_q.pop_front() : 1'bz;
		check_bit(cap_b, e1);
	end
	initial begin
		seed = 23838;
		fail_count = 0;
		total_checks = 0;
		resetn = 1'b0;
		sample = 16'h0000;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		check("cfg", 16'(cfg), 16'h3FFF);
		check("rst", 16'({oe_n, pd, ref_pd, buf_pd}), 16'h000F);
		w = (14'($random(seed)) | 14'h2028) & 14'h3FEF;
		sample <= 16'($random(seed));
		host.start(1'b0);
		repeat (4) @(posedge clk);
		check("conv", 16'({pd, oe_n}), 16'h0001);
		repeat (CONV + 10) @(posedge clk);
		check("done", 16'({pd, oe_n}), 16'h0003);
		push(1'b0, sample);
		sample <= 16'($random(seed));
		host.drop();
		repeat (4) @(posedge clk);
		host.xfer(16, {1'b0, w, 2'($random(seed))}, 1'b1);
		check("cfg", 16'({buf_pd, ref_pd, cfg}), {2'b10, w});
		repeat (6) @(posedge clk);
		check("rel", 16'(oe_n), 16'h0001);
		sample <= 16'($random(seed));
		host.start(1'b1);
		host.xfer(14, {4'b0001, ~w[12:0]}, 1'b0);
		check("hold", 16'({pd, cfg}), 16'({1'b0, w}));
		for (int k = 0; k < 200 && oe_n !== 1'b0; k++)
			@(posedge clk);
		check("wait", 16'(oe_n), 16'h0000);
		if (oe_n === 1'b0) begin
			check("irq", 16'(pd), 16'h0001);
			push(1'b1, sample);
			host.xfer(17, 17'h0_0000, 1'b1);
			check("keep", 16'(cfg), 16'(w));
			repeat (6) @(posedge clk);
			check("rel", 16'(oe_n), 16'h0001);
		end
		check("left", 16'(exp_q.size()), 16'h0000);
		conclude();
	end
endmodule
`default_nettype wire
